//--- hw/rxp_pkg.sv
// rxp_pkg: shared constants and types of the receive output port
package rxp_pkg;
   // character and status widths
   localparam int RXP_CHAR_W = 8;
   localparam int RXP_RAW_W = 10;
   localparam int RXP_STAT_W = 3;
   // fifo word layout: {comma, raw[9:0], dec[7:0], status[2:0]}
   localparam int RXP_ST_LSB = 0;
   localparam int RXP_DEC_LSB = 3;
   localparam int RXP_RAW_LSB = 11;
   localparam int RXP_COMMA_BIT = 21;
   localparam int RXP_WORD_W = 22;
   // bypass layout of the raw character
   localparam int RXP_RAW_LOW_W = 2;
   // buffering depth
   localparam int RXP_FIFO_DEPTH = 16;
   // tx clock synthesis counter width
   localparam int RXP_CNT_W = 8;
   // reset values of outputs
   localparam logic RXP_CLK_RST = 1'h0;
   localparam logic [RXP_CHAR_W-1:0] RXP_CHAR_RST = 8'h00;
   localparam logic [RXP_STAT_W-1:0] RXP_STAT_RST = 3'h0;
   // system clock
   localparam int RXP_MCLK_HZ = 50000000;
   // receive clock pair modes
   typedef enum logic [1:0] {
      RXP_MODE_FULL,
      RXP_MODE_DIV2,
      RXP_MODE_FOLLOW
   } rxp_mode_t;
endpackage

//--- hw/rxp_port.sv
// rxp_port: receive output port with clock pair, tx clock out and fifo
`timescale 1ns/1ps
`default_nettype none

// character fifo, flip-flop storage, registered flags
module rxp_fifo #(
   parameter int WIDTH = 22,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_C = (AW)'(DEPTH-1);

   logic [WIDTH-1:0] mem_ff [DEPTH];  // storage
   logic [WIDTH-1:0] nxt_mem [DEPTH];
   logic [AW-1:0] wr_ff, nxt_wr;      // write index
   logic [AW-1:0] rd_ff, nxt_rd;      // read index
   logic [AW:0] cnt_ff, nxt_cnt;      // fill level
   logic ready_ff, nxt_ready;         // not full
   logic valid_ff, nxt_valid;         // not empty
   logic push, pop;

   // next state of storage, pointers and flags
   always_comb begin
      push = in_valid && ready_ff;
      pop = out_ready && valid_ff;
      nxt_mem = mem_ff;
      nxt_wr = wr_ff;
      nxt_rd = rd_ff;
      nxt_cnt = cnt_ff;
      if (push) begin
         nxt_mem[wr_ff] = in_data;
         nxt_wr = (wr_ff == LAST_C) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
         nxt_rd = (rd_ff == LAST_C) ? '0 : rd_ff + 1'b1;
      end
      if (push && !pop) begin
         nxt_cnt = cnt_ff + 1'b1;
      end else if (pop && !push) begin
         nxt_cnt = cnt_ff - 1'b1;
      end
      // flags registered so both sides see flop outputs
      nxt_ready = (nxt_cnt != DEPTH_C);
      nxt_valid = (nxt_cnt != '0);
   end

   // register only
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
         ready_ff <= 1'b1;
         valid_ff <= 1'b0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
         ready_ff <= nxt_ready;
         valid_ff <= nxt_valid;
      end
      // data storage needs no reset, flags guard it
      mem_ff <= nxt_mem;
   end

   assign in_ready = ready_ff;
   assign out_valid = valid_ff;
   assign out_data = mem_ff[rd_ff];
endmodule

module rxp_port
   import rxp_pkg::*;
#(
   parameter int FIFO_DEPTH = rxp_pkg::RXP_FIFO_DEPTH,
   parameter int CNT_W = rxp_pkg::RXP_CNT_W
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // configuration latches
   input wire logic rx_clock_source_select,
   input wire logic rx_rate_select,
   input wire logic tx_rate_select,
   input wire logic ref_half_rate,
   input wire logic decoder_bypass,
   // clock pins from outside
   input wire logic channel_ref_clock,
   input wire logic rx_recovered_clock,
   // characters from the receive decoder
   input wire logic rx_word_valid,
   output logic rx_word_ready,
   input wire logic [rxp_pkg::RXP_RAW_W-1:0] rx_raw_char,
   input wire logic [rxp_pkg::RXP_CHAR_W-1:0] rx_dec_char,
   input wire logic [rxp_pkg::RXP_STAT_W-1:0] rx_dec_status,
   input wire logic rx_comma_found,
   // host parallel output
   output logic rx_interface_clock_p,
   output logic rx_interface_clock_n,
   output logic [rxp_pkg::RXP_CHAR_W-1:0] rx_char_out,
   output logic [rxp_pkg::RXP_STAT_W-1:0] rx_status_out,
   // transmit clock output
   output logic tx_clock_out,
   output logic tx_char_strobe
);
   import rxp_pkg::*;

   // pin synchronisers: bit 0 reference, bit 1 recovered
   logic [1:0] pin_s1_ff, pin_s2_ff, pin_d_ff;
   logic [1:0] nxt_s1, nxt_s2, nxt_d;
   logic ref_rise, ref_fall, rec_rise, rec_fall;
   logic src_rise, src_fall;          // selected source edges
   rxp_mode_t mode;                   // pair generation mode
   logic char_evt;                    // a character is presented

   // fifo wires
   logic fifo_valid;
   logic [RXP_WORD_W-1:0] fifo_word;
   logic [RXP_WORD_W-1:0] in_word;

   // output registers
   logic clk_ff, nxt_clk;             // true clock of the pair
   logic clkn_ff, nxt_clkn;           // complement clock
   logic [RXP_CHAR_W-1:0] char_ff, nxt_char;
   logic [RXP_STAT_W-1:0] stat_ff, nxt_stat;

   // tx clock synthesis
   logic [CNT_W-1:0] tx_cnt_ff, nxt_tx_cnt;   // cycles since ref edge
   logic [CNT_W-1:0] tx_half_ff, nxt_tx_half; // last ref half period
   logic tx_ff, nxt_tx;
   logic txs_ff, nxt_txs;

   // two-flop synchronisers plus a delay flop; stage two and the delay flop are looked at
   always_comb begin
      nxt_s1 = {rx_recovered_clock, channel_ref_clock};
      nxt_s2 = pin_s1_ff;
      nxt_d = pin_s2_ff;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pin_s1_ff <= '0;
         pin_s2_ff <= '0;
         pin_d_ff <= '0;
      end else begin
         pin_s1_ff <= nxt_s1;
         pin_s2_ff <= nxt_s2;
         pin_d_ff <= nxt_d;
      end
   end

   // edge detection on synchronised levels
   assign ref_rise = pin_s2_ff[0] & ~pin_d_ff[0];
   assign ref_fall = ~pin_s2_ff[0] & pin_d_ff[0];
   assign rec_rise = pin_s2_ff[1] & ~pin_d_ff[1];
   assign rec_fall = ~pin_s2_ff[1] & pin_d_ff[1];

   // source and mode selection
   always_comb begin
      // recovered or reference timing
      src_rise = rx_clock_source_select ? ref_rise : rec_rise;
      src_fall = rx_clock_source_select ? ref_fall : rec_fall;
      if (rx_clock_source_select && ref_half_rate) begin
         // rate setting ignored here
         mode = RXP_MODE_FOLLOW;
      end else if (rx_rate_select) begin
         mode = RXP_MODE_DIV2;
      end else begin
         mode = RXP_MODE_FULL;
      end
      // when a new character goes out
      if (mode == RXP_MODE_FOLLOW) begin
         char_evt = ref_rise | ref_fall;
      end else begin
         char_evt = src_rise;
      end
   end

   // pack decoder side word
   always_comb begin
      in_word = '0;
      in_word[RXP_COMMA_BIT] = rx_comma_found;
      in_word[RXP_RAW_LSB +: RXP_RAW_W] = rx_raw_char;
      in_word[RXP_DEC_LSB +: RXP_CHAR_W] = rx_dec_char;
      in_word[RXP_ST_LSB +: RXP_STAT_W] = rx_dec_status;
   end

   // fifo drains one word per character event
   rxp_fifo #(
      .WIDTH(RXP_WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(mclk),
      .rst(sys_rst),
      .in_valid(rx_word_valid),
      .in_ready(rx_word_ready),
      .in_data(in_word),
      .out_valid(fifo_valid),
      .out_ready(char_evt),
      .out_data(fifo_word)
   );

   // next clock pair and presented character
   always_comb begin
      nxt_clk = clk_ff;
      nxt_char = char_ff;
      nxt_stat = stat_ff;
      case (mode)
         RXP_MODE_FULL: begin
            // high on source rise, low on source fall
            if (src_rise) begin
               nxt_clk = 1'b1;
            end else if (src_fall) begin
               nxt_clk = 1'b0;
            end
         end
         RXP_MODE_DIV2: begin
            // divided copy, toggles once per character
            if (src_rise) begin
               nxt_clk = ~clk_ff;
            end
         end
         RXP_MODE_FOLLOW: begin
            // buffered copy of the reference
            nxt_clk = pin_s2_ff[0];
         end
         default: begin
            nxt_clk = clk_ff;
         end
      endcase
      // complement always opposite, never stops
      nxt_clkn = ~nxt_clk;
      // data and status change in the same cycle as the pair
      if (char_evt && fifo_valid) begin
         if (decoder_bypass) begin
            // raw character split over data and status
            nxt_char = fifo_word[RXP_RAW_LSB+RXP_RAW_LOW_W +: RXP_CHAR_W];
            nxt_stat[RXP_RAW_LOW_W-1:0] =
               fifo_word[RXP_RAW_LSB +: RXP_RAW_LOW_W];
            nxt_stat[RXP_STAT_W-1] = fifo_word[RXP_COMMA_BIT];
         end else begin
            nxt_char = fifo_word[RXP_DEC_LSB +: RXP_CHAR_W];
            nxt_stat = fifo_word[RXP_ST_LSB +: RXP_STAT_W];
         end
      end
      // empty fifo on an event: last character is held
   end

   // register the output group
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         clk_ff <= RXP_CLK_RST;
         clkn_ff <= ~RXP_CLK_RST;
         char_ff <= RXP_CHAR_RST;
         stat_ff <= RXP_STAT_RST;
      end else begin
         clk_ff <= nxt_clk;
         clkn_ff <= nxt_clkn;
         char_ff <= nxt_char;
         stat_ff <= nxt_stat;
      end
   end

   // tx clock: measure ref half period, insert a mid edge for 2x
   always_comb begin
      nxt_tx_cnt = tx_cnt_ff;
      nxt_tx_half = tx_half_ff;
      nxt_tx = tx_ff;
      if (ref_rise || ref_fall) begin
         nxt_tx_half = tx_cnt_ff;
         nxt_tx_cnt = '0;
      end else if (tx_cnt_ff != '1) begin
         // saturate so a stopped ref does not wrap
         nxt_tx_cnt = tx_cnt_ff + 1'b1;
      end
      if (!tx_rate_select) begin
         // same frequency as the reference
         nxt_tx = pin_s2_ff[0];
      end else if (ref_rise || ref_fall) begin
         // rise on every reference edge
         nxt_tx = 1'b1;
      end else if (tx_cnt_ff == (tx_half_ff >> 1)) begin
         // fall halfway through the half period
         nxt_tx = 1'b0;
      end
      // phase to ref set by sync latency, not promised
      // character strobe marks each tx rising edge
      nxt_txs = nxt_tx & ~tx_ff;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tx_cnt_ff <= '0;
         tx_half_ff <= '0;
         tx_ff <= RXP_CLK_RST;
         txs_ff <= 1'b0;
      end else begin
         tx_cnt_ff <= nxt_tx_cnt;
         tx_half_ff <= nxt_tx_half;
         tx_ff <= nxt_tx;
         txs_ff <= nxt_txs;
      end
   end

   // outputs straight from flops
   assign rx_interface_clock_p = clk_ff;
   assign rx_interface_clock_n = clkn_ff;
   assign rx_char_out = char_ff;
   assign rx_status_out = stat_ff;
   assign tx_clock_out = tx_ff;
   assign tx_char_strobe = txs_ff;
endmodule

`default_nettype wire

//--- testbench/rxp_port_asserts.sv
// checker for receive pair, output timing and tx clock
`timescale 1ns/1ps
`default_nettype none
module rxp_port_chk #(
   parameter int FIFO_DEPTH = 16,
   parameter int CNT_W = 8
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // configuration
   input wire logic rx_clock_source_select,
   input wire logic rx_rate_select,
   input wire logic tx_rate_select,
   input wire logic ref_half_rate,
   // clock pins
   input wire logic channel_ref_clock,
   input wire logic rx_recovered_clock,
   // host side outputs
   input wire logic rx_interface_clock_p,
   input wire logic rx_interface_clock_n,
   input wire logic [7:0] rx_char_out,
   input wire logic [2:0] rx_status_out,
   input wire logic tx_clock_out
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   logic [6:0] settle_ff, nxt_settle; // cycles since reset, saturates
   logic ok, fol, div, full, src, p; // settled, modes, source pin, pair
   assign ok = settle_ff == 7'h64;
   assign fol = rx_clock_source_select && ref_half_rate;
   assign div = rx_rate_select && !fol;
   assign full = !rx_rate_select && !fol;
   assign src = rx_clock_source_select ? channel_ref_clock : rx_recovered_clock;
   assign p = rx_interface_clock_p;
   // wait out sync pipeline fill, first period may glitch
   always_comb begin
      nxt_settle = settle_ff;
      if (sys_rst) begin
         nxt_settle = 7'h00;
      end else if (!ok) begin
         nxt_settle = settle_ff + 7'h01;
      end
   end
   always_ff @(posedge mclk) begin
      settle_ff <= nxt_settle;
   end
   sequence s_moves; ##[1:6] $changed(p); endsequence
   sequence s_rests; ##3 $stable(p) [*3]; endsequence
   property p_compl; rx_interface_clock_n == !p; endproperty
   property p_data; $changed({rx_char_out, rx_status_out}) |-> $changed(p); endproperty
   property p_full; full && $changed(rx_char_out) |-> $rose(p); endproperty
   property p_src; ok && !div && $changed(src) |-> s_moves; endproperty
   property p_divr; ok && div && $rose(src) |-> s_moves; endproperty
   property p_divf; ok && div && $fell(src) |-> s_rests; endproperty
   property p_tx0; ok && !tx_rate_select && $rose(tx_clock_out) |-> $past(channel_ref_clock, 2);
   endproperty
   property p_tx1; ok && tx_rate_select && $changed(channel_ref_clock) |->
      ##[1:6] $rose(tx_clock_out); endproperty
   a_compl: assert property (p_compl) else $error("pair not complementary");
   a_data: assert property (p_data) else $error("data moved without pair");
   a_full: assert property (p_full) else $error("data off true rise");
   a_src: assert property (p_src) else $error("pair missed source edge");
   a_divr: assert property (p_divr) else $error("divided pair missed rise");
   a_divf: assert property (p_divf) else $error("divided pair moved on fall");
   a_tx0: assert property (p_tx0) else $error("tx clock off reference");
   a_tx1: assert property (p_tx1) else $error("tx clock missed edge");
endmodule
bind rxp_port rxp_port_chk #(.FIFO_DEPTH(FIFO_DEPTH), .CNT_W(CNT_W)) i_rxp_port_chk (
   .mclk, .sys_rst, .rx_clock_source_select, .rx_rate_select, .tx_rate_select,
   .ref_half_rate, .channel_ref_clock, .rx_recovered_clock, .rx_interface_clock_p,
   .rx_interface_clock_n, .rx_char_out, .rx_status_out, .tx_clock_out);
`default_nettype wire

//--- testbench/rxp_host_cap.sv
// host capture model: takes character and status on pair edges
`timescale 1ns/1ps
`default_nettype none
module rxp_host_cap (
   // clock and capture mode
   input wire logic mclk,
   input wire logic both_edges,
   // receive pair, character, status
   input wire logic pair_p,
   input wire logic pair_n,
   input wire logic [7:0] char_in,
   input wire logic [2:0] stat_in,
   // captured word
   output logic cap_stb,
   output logic [10:0] cap_word
);
   logic p_ff; // pair level last cycle
   // true rise only at full rate, both edges at half rate
   always_ff @(posedge mclk) begin
      p_ff <= pair_p;
      cap_stb <= (pair_p && !pair_n && !p_ff) || (both_edges && pair_p != p_ff);
      cap_word <= {char_in, stat_in};
   end
endmodule
`default_nettype wire

//--- testbench/test_rx_parallel_output_clocking.sv
// bench: receive port against a queue model in four modes
`timescale 1ns/1ps
`default_nettype none
module test_rx_parallel_output_clocking;
   import rxp_pkg::*;
   // mode words {source, rate, half ref, bypass, tx rate}
   localparam logic [4:0] MODES [4] = '{5'h00, 5'h1B, 5'h1E, 5'h0D};
   logic mclk, sys_rst, sel, rate, txr, half, byp, refc, recc, vld, cma, ready;
   logic pp, pn, txo, stb, cap_stb, srcw;
   logic pp_q; // pair level at the last edge, for rise counting
   logic [9:0] raw;
   logic [7:0] dec, ch;
   logic [2:0] dst, st;
   logic [10:0] cap_word, last; // captured and last consumed word
   logic [10:0] expq [$]; // words the host should see, in order
   logic [4:0] md;
   int bad_count, check_count, cyc, np, nt, dp, dt, acc;
   assign srcw = sel ? refc : recc;
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   rxp_port i_rxp_port (.mclk, .sys_rst, .rx_clock_source_select(sel),
      .rx_rate_select(rate), .tx_rate_select(txr), .ref_half_rate(half),
      .decoder_bypass(byp), .channel_ref_clock(refc), .rx_recovered_clock(recc),
      .rx_word_valid(vld), .rx_word_ready(ready), .rx_raw_char(raw), .rx_dec_char(dec),
      .rx_dec_status(dst), .rx_comma_found(cma), .rx_interface_clock_p(pp),
      .rx_interface_clock_n(pn), .rx_char_out(ch), .rx_status_out(st),
      .tx_clock_out(txo), .tx_char_strobe(stb));
   rxp_host_cap i_rxp_host_cap (.mclk, .both_edges(rate || (sel && half)),
      .pair_p(pp), .pair_n(pn), .char_in(ch), .stat_in(st), .cap_stb, .cap_word);
   task automatic chk_cnt(input string nm, input int e, input int g);
      check_count++;
      if (e != g) begin
         bad_count++;
         $display("BAD %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic chk_word(input string nm, input logic [10:0] e, input logic [10:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // pin clocks of 40 cycles, recovered offset; counts; host check; timeout
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      refc <= (cyc % 40) < 20;
      recc <= ((cyc + 7) % 40) < 20;
      pp_q <= pp;
      if (pp === 1'b1 && pp_q === 1'b0) np <= np + 1;
      if (stb === 1'b1) nt <= nt + 1;
      // empty fifo holds the last word, else next word in order
      if (cap_stb === 1'b1 && !sys_rst) begin
         if (expq.size() > 0 && cap_word === expq[0]) last = expq.pop_front();
         chk_word("host word", last, cap_word);
      end
      if (cyc == 20000) begin
         bad_count++;
         give_verdict();
      end
   end
   // mode set only under reset, then wait for syncs to settle
   task automatic do_reset(input logic [4:0] mw);
      @(posedge mclk);
      sys_rst <= 1'b1;
      {sel, rate, half, byp, txr} <= mw;
      repeat (6) @(posedge mclk);
      expq.delete();
      last = 11'h000;
      sys_rst <= 1'b0;
      repeat (100) @(posedge mclk);
   endtask
   // pair and tx rises over eight source periods
   task automatic measure(output int p, output int t);
      int p0, t0;
      @(posedge srcw);
      @(negedge mclk);
      p0 = np;
      t0 = nt;
      repeat (8) @(posedge srcw);
      @(negedge mclk);
      p = np - p0;
      t = nt - t0;
   endtask
   // push right after a pair edge so no pop lands before the fifo refuses
   task automatic fill();
      @(pp);
      vld <= 1'b1;
      {raw, dec, dst, cma} <= 22'($urandom);
      repeat (17) begin
         @(posedge mclk);
         if (ready === 1'b1) begin
            acc++;
            expq.push_back(byp ? {raw[9:2], cma, raw[1:0]} : {dec, dst});
            {raw, dec, dst, cma} <= 22'($urandom);
         end
      end
      vld <= 1'b0;
   endtask
   initial begin
      sys_rst = 1'b1;
      {sel, rate, half, byp, txr, vld, cma} = 7'h00;
      {raw, dec, dst} = 21'h0;
      last = 11'h000;
      void'($urandom(32'h87319AF9));
      for (int m = 0; m < 4; m++) begin
         md = MODES[m];
         do_reset(md);
         measure(dp, dt);
         chk_cnt("pair rises", (md[3] && !(md[4] && md[2])) ? 4 : 8, dp);
         chk_cnt("tx clock rises", md[0] ? 16 : 8, dt);
         acc = 0;
         fill();
         chk_cnt("accepted words", RXP_FIFO_DEPTH, acc);
         for (int k = 0; k < 2000 && expq.size() > 0; k++) @(posedge mclk);
         chk_cnt("words left", 0, expq.size());
      end
      give_verdict();
   end
endmodule
`default_nettype wire
